// ---- rtl/asfs_core.sv ----
// Design decision made here: the APB register port.
`timescale 1ns/1ps
`default_nettype none

// Function
// [RQ1] Nine-bit mode: received bit 8 captured with the buffer byte, read only.
// [RQ2] Eight-bit mode: received ninth status copies bit 7; reset leaves it.
// [RQ3] Nine-bit mode: transmit ninth bit goes out with the byte; reset clears it.
// [RQ4] Four enables gate overrun, noise, framing, parity error requests; reset clears.
// [RQ5] Transmit-empty sets on hand-off to shifter; interrupts if enabled; reset sets.
// [RQ6] Transmit-empty clears only by status one read with flag, then buffer write.
// [RQ7] Transmission-complete sets when empty and nothing sent; interrupts; reset sets.
// [RQ8] Transmission-complete clears once data, preamble or break is queued.
// [RQ9] Receiver-full sets on buffer load, interrupts; cleared by status-then-buffer reads.
// [RQ10] Idle flag sets after 10 or 11 consecutive ones; interrupts if enabled.
// [RQ11] Idle needs a receiver-full event after enable or after its clear.
// [RQ12] Character arriving while full sets overrun, is discarded, buffer kept.
// [RQ13] Buffer read clears only error flags seen set at the prior status read.
// [RQ14] Noise flag sets on noise, interrupts if enabled, cleared by read sequence.
// [RQ15] Framing flag sets on zero stop bit, interrupts, clears by read sequence.
// [RQ16] Parity flag sets on mismatch, interrupts, clears by read sequence.
// [RQ17] Break sets break, framing, full, clears ninth bit in nine-bit mode.
// [RQ18] After break clears, rearm only after ones then another break.
// [RQ19] Reception-in-progress sets on zero at first slot, clears on false start or idle.
// [RQ20] Data address reads receive buffer, writes transmit buffer; reset leaves contents.
// [RQ21] Character-length bit selects eight or nine bit ninth-bit behaviour.
// [RQ22] Enabled error flags combine into one level error interrupt request.
module asfs_core
  import asfs_pkg::*;
(
  input  wire logic                   core_clk_i,
  input  wire logic                   rstn_i,
  input  wire logic                   psel_i,
  input  wire logic                   penable_i,
  input  wire logic                   pwrite_i,
  input  wire logic [ASFS_ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]            pwdata_i,
  output logic      [31:0]            prdata_o,
  output logic                        pready_o,
  output logic                        pslverr_o,
  input  wire logic                   rxd_i,
  input  wire logic                   rx_bit_tick_i,
  input  wire logic                   rx_char_done_i,
  input  wire logic [8:0]             rx_word_i,
  input  wire logic                   rx_noise_i,
  input  wire logic                   rx_frame_err_i,
  input  wire logic                   rx_parity_err_i,
  input  wire logic                   rx_break_i,
  input  wire logic                   rx_start_low_i,
  input  wire logic                   rx_false_start_i,
  input  wire logic                   tx_load_i,
  input  wire logic                   tx_busy_i,
  output logic      [8:0]             tx_word_o,
  output logic                        tx_pending_o,
  output logic                        nine_bit_mode_o,
  output logic                        rx_enable_o,
  output logic                        tx_irq_o,
  output logic                        rx_irq_o,
  output logic                        err_irq_o
);

  logic [7:0] ctrl_aux_r;
  logic [3:0] err_en_r;
  logic       tx_ninth_r;
  logic       rx_ninth_r;
  logic [7:0] rx_buf_r;
  logic [7:0] tx_buf_r;
  logic       tx_empty_r;
  logic       tx_done_r;
  logic       rx_full_r;
  logic       idle_r;
  logic       overrun_r;
  logic       noise_r;
  logic       framing_r;
  logic       parity_r;
  logic       break_r;
  logic       active_r;
  logic       idle_arm_r;
  logic       break_arm_r;
  logic       rx_en_d_r;
  logic [7:0] snap1_r;
  logic       snap_brk_r;
  logic [3:0] ones_cnt_r;
  logic [3:0] ones_nxt;
  logic       rxd_meta_r;
  logic       rxd_sync_r;
  logic       pready_r;
  logic       pslverr_r;
  logic [31:0] prdata_r;
  logic [31:0] rdata;
  logic       hit;
  logic [7:0] word_idx;
  logic       setup;
  logic       done;
  logic       wr_done;
  logic       rd_done;
  logic       rd_s1;
  logic       rd_s2;
  logic       rd_buf;
  logic       wr_buf;
  logic       nine;
  logic       take_char;
  logic       overrun_ev;
  logic       break_ev;
  logic       idle_char;
  logic       idle_clr;
  logic [3:0] idle_len;
  logic [7:0] status_one;
  logic [7:0] status_two;
  logic [7:0] ctrl_three;

  // Receive pin comes from outside, so it is synchronised first
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      rxd_meta_r <= 1'b1;
      rxd_sync_r <= 1'b1;
    end else begin
      rxd_meta_r <= rxd_i;
      rxd_sync_r <= rxd_meta_r;
    end
  end

  // Bus phase decode; only word-aligned addresses hit a register
  assign word_idx = paddr_i[9:2];
  assign setup    = psel_i & ~penable_i;
  assign done     = psel_i & penable_i & pready_r;
  assign wr_done  = done & pwrite_i & ~pslverr_r;
  assign rd_done  = done & ~pwrite_i & ~pslverr_r;
  assign rd_s1    = rd_done & (word_idx == ASFS_IDX_STATUS_ONE);
  assign rd_s2    = rd_done & (word_idx == ASFS_IDX_STATUS_TWO);
  assign rd_buf   = rd_done & (word_idx == ASFS_IDX_DATA_BUFFER);
  assign wr_buf   = wr_done & (word_idx == ASFS_IDX_DATA_BUFFER);
  assign nine     = ctrl_aux_r[ASFS_CA_NINE]; // [RQ21]

  // Register views
  assign status_one = {tx_empty_r, tx_done_r, rx_full_r, idle_r,
                       overrun_r, noise_r, framing_r, parity_r};
  assign status_two = {6'h00, break_r, active_r};
  assign ctrl_three = {rx_ninth_r, tx_ninth_r, 2'h0, err_en_r};

  // Read mux; unmapped or unaligned addresses flag an error
  always_comb begin
    rdata = 32'h0000_0000;
    hit   = (paddr_i[1:0] == 2'h0) && (paddr_i[ASFS_ADDR_W-1:10] == '0);
    case (word_idx)
      ASFS_IDX_CONTROL_AUX:   rdata[7:0] = ctrl_aux_r;
      ASFS_IDX_CONTROL_THREE: rdata[7:0] = ctrl_three;
      ASFS_IDX_STATUS_ONE:    rdata[7:0] = status_one;
      ASFS_IDX_STATUS_TWO:    rdata[7:0] = status_two;
      ASFS_IDX_DATA_BUFFER:   rdata[7:0] = rx_buf_r; // [RQ20]
      default:                hit = 1'b0;
    endcase
  end

  // One wait-free access phase: answer is registered at the setup edge
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else if (setup) begin
      pready_r  <= 1'b1;
      pslverr_r <= ~hit;
      prdata_r  <= pwrite_i ? 32'h0000_0000 : rdata;
    end else if (done) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end
  end

  // Software control bits; status and receive ninth bit are read only
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      ctrl_aux_r <= ASFS_CA_RESET;
      err_en_r   <= ASFS_EN_RESET; // [RQ4]
      tx_ninth_r <= 1'b0; // [RQ3]
    end else if (wr_done) begin
      if (word_idx == ASFS_IDX_CONTROL_AUX) begin
        ctrl_aux_r <= pwdata_i[7:0] & 8'hf3;
      end
      if (word_idx == ASFS_IDX_CONTROL_THREE) begin
        err_en_r   <= pwdata_i[3:0]; // [RQ4]
        tx_ninth_r <= pwdata_i[ASFS_C3_TX_NINTH]; // [RQ3]
      end
    end
  end

  // Status snapshot; a flag raised after this read survives the buffer access
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      snap1_r    <= 8'h00;
      snap_brk_r <= 1'b0;
    end else begin
      if (rd_s1) begin
        snap1_r <= status_one; // [RQ13]
      end else if (rd_buf || wr_buf) begin
        snap1_r <= 8'h00;
      end
      if (rd_s2) begin
        snap_brk_r <= break_r;
      end else if (rd_buf) begin
        snap_brk_r <= 1'b0;
      end
    end
  end

  // Transmit buffer; no reset so contents survive it
  always_ff @(posedge core_clk_i) begin
    if (wr_buf) begin
      tx_buf_r <= pwdata_i[7:0]; // [RQ20]
    end
  end

  // Transmit-empty: set wins over the software clear
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      tx_empty_r <= 1'b1; // [RQ5]
    end else if (tx_load_i) begin
      tx_empty_r <= 1'b1; // [RQ5]
    end else if (wr_buf && snap1_r[ASFS_S1_TX_EMPTY]) begin
      tx_empty_r <= 1'b0; // [RQ6]
    end
  end

  // Complete while empty and shifter has nothing sent or queued
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      tx_done_r <= 1'b1; // [RQ7]
    end else if (tx_busy_i) begin
      tx_done_r <= 1'b0; // [RQ8]
    end else if (tx_empty_r) begin
      tx_done_r <= 1'b1; // [RQ7]
    end
  end

  // A character is kept only when the buffer is free
  assign overrun_ev = rx_char_done_i & rx_full_r; // [RQ12]
  assign take_char  = rx_char_done_i & ~rx_full_r;
  assign break_ev   = rx_break_i & break_arm_r; // [RQ18]

  // Receive buffer and ninth bit carry no reset
  always_ff @(posedge core_clk_i) begin
    if (take_char) begin
      rx_buf_r   <= rx_word_i[7:0]; // [RQ20]
      rx_ninth_r <= nine ? rx_word_i[8] : rx_word_i[7]; // [RQ1] [RQ2]
    end else if (break_ev && nine) begin
      rx_ninth_r <= 1'b0; // [RQ17]
    end
  end

  // Receiver-full
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      rx_full_r <= 1'b0;
    end else if (take_char || break_ev) begin
      rx_full_r <= 1'b1; // [RQ9] [RQ17]
    end else if (rd_buf && snap1_r[ASFS_S1_RX_FULL]) begin
      rx_full_r <= 1'b0; // [RQ9]
    end
  end

  // Error flags; each event beats a clear in the same cycle
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      overrun_r <= 1'b0;
      noise_r   <= 1'b0;
      framing_r <= 1'b0;
      parity_r  <= 1'b0;
    end else begin
      if (overrun_ev) begin
        overrun_r <= 1'b1; // [RQ12]
      end else if (rd_buf && snap1_r[ASFS_S1_OVERRUN]) begin
        overrun_r <= 1'b0; // [RQ13]
      end
      if (rx_noise_i) begin
        noise_r <= 1'b1; // [RQ14]
      end else if (rd_buf && snap1_r[ASFS_S1_NOISE]) begin
        noise_r <= 1'b0; // [RQ14] [RQ13]
      end
      if ((take_char && rx_frame_err_i) || break_ev) begin
        framing_r <= 1'b1; // [RQ15] [RQ17]
      end else if (rd_buf && snap1_r[ASFS_S1_FRAMING]) begin
        framing_r <= 1'b0; // [RQ15] [RQ13]
      end
      if (take_char && rx_parity_err_i) begin
        parity_r <= 1'b1; // [RQ16]
      end else if (rd_buf && snap1_r[ASFS_S1_PARITY]) begin
        parity_r <= 1'b0; // [RQ16] [RQ13]
      end
    end
  end

  // Break flag; rearmed only once the line has gone high again
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      break_r     <= 1'b0;
      break_arm_r <= 1'b1;
    end else begin
      if (break_ev) begin
        break_r     <= 1'b1; // [RQ17]
        break_arm_r <= 1'b0; // [RQ18]
      end else begin
        if (rd_buf && snap_brk_r) begin
          break_r <= 1'b0; // [RQ17]
        end
        if (rxd_sync_r && !break_r) begin
          break_arm_r <= 1'b1; // [RQ18]
        end
      end
    end
  end

  // Count ones in bit times; a low bit restarts the count
  assign idle_len = nine ? ASFS_IDLE_BITS_9 : ASFS_IDLE_BITS_8; // [RQ10]
  always_comb begin
    ones_nxt = ones_cnt_r;
    if (rx_bit_tick_i) begin
      if (!rxd_sync_r) begin
        ones_nxt = 4'h0;
      end else if (ones_cnt_r != idle_len) begin
        ones_nxt = ones_cnt_r + 4'h1;
      end
    end
  end
  assign idle_char = rx_bit_tick_i & rxd_sync_r & (ones_nxt == idle_len) & (ones_cnt_r != idle_len);

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      ones_cnt_r <= 4'h0;
    end else if (!ctrl_aux_r[ASFS_CA_RX_EN]) begin
      ones_cnt_r <= 4'h0;
    end else begin
      ones_cnt_r <= ones_nxt; // [RQ10]
    end
  end

  // Idle flag waits for a received character after enable or after its clear
  assign idle_clr = rd_buf & snap1_r[ASFS_S1_IDLE];
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      idle_r     <= 1'b0;
      idle_arm_r <= 1'b0;
      rx_en_d_r  <= 1'b0;
    end else begin
      rx_en_d_r <= ctrl_aux_r[ASFS_CA_RX_EN];
      if (idle_char && idle_arm_r) begin
        idle_r     <= 1'b1; // [RQ10]
        idle_arm_r <= 1'b0; // [RQ11]
      end else begin
        if (idle_clr) begin
          idle_r <= 1'b0;
        end
        if (take_char) begin
          idle_arm_r <= 1'b1; // [RQ11]
        end else if (idle_clr || (ctrl_aux_r[ASFS_CA_RX_EN] && !rx_en_d_r)) begin
          idle_arm_r <= 1'b0; // [RQ11]
        end
      end
    end
  end

  // Reception in progress; a new start edge wins over a clear
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      active_r <= 1'b0;
    end else if (rx_start_low_i) begin
      active_r <= 1'b1; // [RQ19]
    end else if (rx_false_start_i || idle_char) begin
      active_r <= 1'b0; // [RQ19]
    end
  end

  // Interrupt requests registered so the outputs are flops
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      tx_irq_o  <= 1'b0;
      rx_irq_o  <= 1'b0;
      err_irq_o <= 1'b0;
    end else begin
      tx_irq_o  <= (tx_empty_r & ctrl_aux_r[ASFS_CA_TXE_EN]) // [RQ5]
                 | (tx_done_r & ctrl_aux_r[ASFS_CA_TXD_EN]); // [RQ7]
      rx_irq_o  <= (rx_full_r & ctrl_aux_r[ASFS_CA_RXF_EN]) // [RQ9]
                 | (idle_r & ctrl_aux_r[ASFS_CA_IDL_EN]); // [RQ10]
      err_irq_o <= (overrun_r & err_en_r[ASFS_C3_OR_EN]) // [RQ4] [RQ22]
                 | (noise_r & err_en_r[ASFS_C3_NE_EN])
                 | (framing_r & err_en_r[ASFS_C3_FE_EN])
                 | (parity_r & err_en_r[ASFS_C3_PE_EN]);
    end
  end

  // Outputs straight from flops
  assign prdata_o        = prdata_r;
  assign pready_o        = pready_r;
  assign pslverr_o       = pslverr_r;
  assign tx_word_o       = {tx_ninth_r, tx_buf_r}; // [RQ3]
  assign tx_pending_o    = ~tx_empty_r;
  assign nine_bit_mode_o = ctrl_aux_r[ASFS_CA_NINE];
  assign rx_enable_o     = ctrl_aux_r[ASFS_CA_RX_EN];

endmodule

`default_nettype wire

// ---- inc/asfs_pkg.sv ----
package asfs_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] ASFS_IDX_CONTROL_AUX   = 8'h14;
  localparam logic [7:0] ASFS_IDX_CONTROL_THREE = 8'h15;
  localparam logic [7:0] ASFS_IDX_STATUS_ONE    = 8'h16;
  localparam logic [7:0] ASFS_IDX_STATUS_TWO    = 8'h17;
  localparam logic [7:0] ASFS_IDX_DATA_BUFFER   = 8'h18;
  localparam int         ASFS_ADDR_W            = 12;

  // Status one field positions
  localparam int ASFS_S1_TX_EMPTY = 7;
  localparam int ASFS_S1_TX_DONE  = 6;
  localparam int ASFS_S1_RX_FULL  = 5;
  localparam int ASFS_S1_IDLE     = 4;
  localparam int ASFS_S1_OVERRUN  = 3;
  localparam int ASFS_S1_NOISE    = 2;
  localparam int ASFS_S1_FRAMING  = 1;
  localparam int ASFS_S1_PARITY   = 0;

  // Status two field positions
  localparam int ASFS_S2_BREAK    = 1;
  localparam int ASFS_S2_ACTIVE   = 0;

  // Control three field positions
  localparam int ASFS_C3_RX_NINTH = 7;
  localparam int ASFS_C3_TX_NINTH = 6;
  localparam int ASFS_C3_OR_EN    = 3;
  localparam int ASFS_C3_NE_EN    = 2;
  localparam int ASFS_C3_FE_EN    = 1;
  localparam int ASFS_C3_PE_EN    = 0;

  // Auxiliary control field positions
  localparam int ASFS_CA_TXE_EN   = 7;
  localparam int ASFS_CA_TXD_EN   = 6;
  localparam int ASFS_CA_RXF_EN   = 5;
  localparam int ASFS_CA_IDL_EN   = 4;
  localparam int ASFS_CA_NINE     = 1;
  localparam int ASFS_CA_RX_EN    = 0;

  // Reset values
  localparam logic [7:0] ASFS_CA_RESET = 8'h00;
  localparam logic [3:0] ASFS_EN_RESET = 4'h0;

  // Idle line lengths in bit times
  localparam logic [3:0] ASFS_IDLE_BITS_8 = 4'ha;
  localparam logic [3:0] ASFS_IDLE_BITS_9 = 4'hb;
endpackage

// ---- sim/asfs_far_node.sv ----
`timescale 1ns/1ps
`default_nettype none
// Remote transmit shifter: takes buffered words after a random delay
module asfs_far_node (
  input  wire logic       core_clk_i,
  input  wire logic       rstn_i,
  input  wire logic       tx_pending_i,
  input  wire logic [8:0] tx_word_i,
  output logic            tx_load_o,
  output logic            tx_busy_o,
  output logic      [8:0] last_word_o,
  output logic      [7:0] loads_o
);
  logic [3:0] dly_r;
  logic [3:0] cnt_r;
  logic       shift_r;
  // Queued word already counts as busy, so done drops no later than the shift starts
  assign tx_busy_o = tx_pending_i | shift_r;
  // Shift timing; delay varies so both prompt and slow takes are seen
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      tx_load_o <= 1'b0;
      shift_r   <= 1'b0;
      cnt_r     <= 4'h0;
      dly_r     <= 4'h0;
      loads_o   <= 8'h00;
    end else begin
      tx_load_o <= 1'b0;
      if (shift_r) begin
        cnt_r <= cnt_r - 4'h1;
        if (cnt_r == 4'h1) shift_r <= 1'b0;
      end else if (tx_pending_i && !tx_load_o) begin
        if (dly_r == 4'h0) begin
          tx_load_o   <= 1'b1;
          shift_r     <= 1'b1;
          cnt_r       <= 4'hc;
          last_word_o <= tx_word_i;
          loads_o     <= loads_o + 8'h01;
          dly_r       <= 4'($urandom_range(0, 5));
        end else begin
          dly_r <= dly_r - 4'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- sim/asfs_core_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module asfs_core_props
  import asfs_pkg::*;
(
  input wire logic                   core_clk_i,
  input wire logic                   rstn_i,
  input wire logic                   psel_i,
  input wire logic                   penable_i,
  input wire logic                   pwrite_i,
  input wire logic [ASFS_ADDR_W-1:0] paddr_i,
  input wire logic [31:0]            pwdata_i,
  input wire logic                   pready_o,
  input wire logic                   rx_char_done_i,
  input wire logic                   rx_noise_i,
  input wire logic                   rx_break_i,
  input wire logic                   tx_load_i,
  input wire logic [8:0]             tx_word_o,
  input wire logic                   tx_pending_o,
  input wire logic                   nine_bit_mode_o,
  input wire logic                   rx_enable_o,
  input wire logic                   err_irq_o
);
  localparam logic [11:0] A_AUX = {2'b00, ASFS_IDX_CONTROL_AUX, 2'b00};
  localparam logic [11:0] A_C3  = {2'b00, ASFS_IDX_CONTROL_THREE, 2'b00};
  localparam logic [11:0] A_DAT = {2'b00, ASFS_IDX_DATA_BUFFER, 2'b00};
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  // Access edge of a transfer, where side effects land
  sequence s_acc;
    psel_i && penable_i && pready_o;
  endsequence
  sequence s_wr(logic [11:0] a);
    s_acc ##0 (pwrite_i && paddr_i == a);
  endsequence
  // Causes that may raise or drop the error request
  logic wr_c3, rd_dat, rx_ev;
  assign wr_c3  = psel_i && penable_i && pready_o && pwrite_i && paddr_i == A_C3;
  assign rd_dat = psel_i && penable_i && pready_o && !pwrite_i && paddr_i == A_DAT;
  assign rx_ev  = rx_char_done_i || rx_noise_i || rx_break_i || wr_c3;
  a_load_sets_empty: assert property (tx_load_i |=> !tx_pending_o)
    else $error("pending stayed after shifter load");
  a_pend_needs_write: assert property ($rose(tx_pending_o) |-> $past(pwrite_i && paddr_i == A_DAT))
    else $error("pending rose without data write");
  a_data_to_word: assert property (s_wr(A_DAT) |=> tx_word_o[7:0] == $past(pwdata_i[7:0]))
    else $error("transmit byte not loaded");
  a_ninth_to_word: assert property (s_wr(A_C3) |=> tx_word_o[8] == $past(pwdata_i[ASFS_C3_TX_NINTH]))
    else $error("transmit ninth bit not loaded");
  a_mode_bits_set: assert property (s_wr(A_AUX) |=> nine_bit_mode_o == $past(pwdata_i[ASFS_CA_NINE])
    && rx_enable_o == $past(pwdata_i[ASFS_CA_RX_EN]))
    else $error("mode bits not loaded");
  a_reset_values: assert property ($rose(rstn_i) |-> !tx_pending_o && !tx_word_o[8] && !err_irq_o)
    else $error("wrong state after reset");
  a_err_rise_cause: assert property ($rose(err_irq_o) |-> $past(rx_ev, 2) || $past(rx_ev, 3)
    || $past(rx_ev, 4))
    else $error("error request rose without cause");
  a_err_fall_cause: assert property ($fell(err_irq_o) |-> $past(rd_dat || wr_c3, 2)
    || $past(rd_dat || wr_c3, 3))
    else $error("error request fell without clear");
endmodule
`default_nettype wire

// ---- sim/asfs_core_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module asfs_core_tb_top;
  import asfs_pkg::*;
  localparam logic [11:0] A_AUX = {2'b00, ASFS_IDX_CONTROL_AUX, 2'b00};
  localparam logic [11:0] A_C3  = {2'b00, ASFS_IDX_CONTROL_THREE, 2'b00};
  localparam logic [11:0] A_S1  = {2'b00, ASFS_IDX_STATUS_ONE, 2'b00};
  localparam logic [11:0] A_S2  = {2'b00, ASFS_IDX_STATUS_TWO, 2'b00};
  localparam logic [11:0] A_DAT = {2'b00, ASFS_IDX_DATA_BUFFER, 2'b00};
  logic core_clk_i = 0, rstn_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0, rxd_i = 1;
  logic rx_bit_tick_i = 0, rx_char_done_i = 0, rx_noise_i = 0, rx_frame_err_i = 0;
  logic rx_parity_err_i = 0, rx_break_i = 0, rx_start_low_i = 0, rx_false_start_i = 0;
  logic [11:0] paddr_i = '0;
  logic [31:0] pwdata_i = '0, prdata_o, q;
  logic [8:0]  rx_word_i = '0, tx_word_o, last_w, w, a;
  logic [7:0]  loads;
  logic pready_o, pslverr_o, tx_load_i, tx_busy_i, tx_pending_o, nine_bit_mode_o;
  logic rx_enable_o, tx_irq_o, rx_irq_o, err_irq_o, e;
  int   err_count = 0, checks = 0;
  asfs_core dut (.*);
  asfs_far_node far (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .tx_pending_i(tx_pending_o),
    .tx_word_i(tx_word_o), .tx_load_o(tx_load_i), .tx_busy_o(tx_busy_i), .last_word_o(last_w),
    .loads_o(loads));
  initial forever #5 core_clk_i = ~core_clk_i;
  // Expected ninth status bit for the character length in use
  function automatic logic f_ninth(input logic [8:0] c, input logic nine);
    return nine ? c[8] : c[7];
  endfunction
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    checks++;
    if (g !== x) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, x, g);
    end
  endtask
  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d);
    @(posedge core_clk_i);
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {2'b10, wr, ad, d};
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    @(posedge core_clk_i);
    while (pready_o !== 1'b1) @(posedge core_clk_i);
    q = prdata_o;
    e = pslverr_o;
    {psel_i, penable_i} <= 2'b00;
  endtask
  task automatic wr(input logic [11:0] ad, input logic [7:0] d);
    apb(1'b1, ad, {24'h0, d});
  endtask
  task automatic rc(input logic [11:0] ad, input logic [7:0] m, input logic [7:0] x, input string n);
    apb(1'b0, ad, 32'h0);
    chk(n, {24'h0, x & m}, q & {24'h0, m});
  endtask
  task automatic clr;
    apb(1'b0, A_S1, 32'h0);
    apb(1'b0, A_DAT, 32'h0);
  endtask
  // One-cycle receiver event: noise, break, start low, false start, bit tick
  task automatic ev(input int k);
    @(posedge core_clk_i);
    case (k)
      0: rx_noise_i <= 1'b1;
      1: rx_break_i <= 1'b1;
      2: rx_start_low_i <= 1'b1;
      3: rx_false_start_i <= 1'b1;
      default: rx_bit_tick_i <= 1'b1;
    endcase
    @(posedge core_clk_i);
    {rx_noise_i, rx_break_i, rx_start_low_i, rx_false_start_i, rx_bit_tick_i} <= 5'h00;
  endtask
  task automatic ticks(input int n);
    repeat (n) ev(4);
  endtask
  // Finished character; word inverted afterwards so stale values never match
  task automatic rxc(input logic [8:0] c, input logic f, input logic p);
    @(posedge core_clk_i);
    {rx_char_done_i, rx_word_i, rx_frame_err_i, rx_parity_err_i} <= {1'b1, c, f, p};
    @(posedge core_clk_i);
    {rx_char_done_i, rx_word_i, rx_frame_err_i, rx_parity_err_i} <= {1'b0, ~c, 2'b00};
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Watchdog: run needs a few hundred cycles
  initial begin
    #200000;
    err_count++;
    report_and_stop();
  end
  initial begin
    void'($urandom(32'haf33a97d));
    repeat (10) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    rc(A_S1, 8'hff, 8'hc0, "status one reset");
    rc(A_S2, 8'hff, 8'h00, "status two reset");
    rc(A_C3, 8'h7f, 8'h00, "control three reset");
    apb(1'b0, 12'h000, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, q);
    w = 9'($urandom);
    wr(A_C3, w[7:0]);
    rc(A_C3, 8'h7f, w[7:0] & 8'h4f, "control three rw");
    for (int i = 0; i < 4; i++) begin
      w = 9'($urandom);
      wr(A_AUX, {6'h20, i[0], 1'b1});
      wr(A_C3, {1'b0, w[8], 6'h0});
      rc(A_S1, 8'h80, 8'h80, "tx empty");
      wr(A_DAT, w[7:0]);
      rc(A_S1, 8'h40, 8'h00, "tx done busy");
      while (tx_busy_i) @(posedge core_clk_i);
      repeat (3) @(posedge core_clk_i);
      chk("tx word", {23'h0, w}, {23'h0, last_w});
      rc(A_S1, 8'hc0, 8'hc0, "tx flags");
      chk("tx irq", 1, tx_irq_o);
    end
    // A data read wipes the status snapshot, so the write below must not clear the flag
    apb(1'b0, A_DAT, 32'h0);
    wr(A_DAT, 8'($urandom));
    @(posedge core_clk_i);
    chk("pending no status", 0, tx_pending_o);
    chk("shifter loads", 4, {24'h0, loads});
    for (int i = 0; i < 6; i++) begin
      wr(A_AUX, {6'h0, i[0], 1'b1});
      w = 9'($urandom);
      rxc(w, 1'b0, 1'b0);
      rc(A_S1, 8'h20, 8'h20, "rx full");
      rc(A_DAT, 8'hff, w[7:0], "rx data");
      rc(A_C3, 8'h80, {f_ninth(w, i[0]), 7'h0}, "rx ninth");
      rc(A_S1, 8'h20, 8'h00, "rx full clear");
    end
    wr(A_C3, 8'h0f);
    w = 9'($urandom);
    rxc(w, 1'b1, 1'b1);
    rc(A_S1, 8'h23, 8'h23, "frame parity");
    chk("err irq", 1, err_irq_o);
    ev(0);
    rc(A_DAT, 8'hff, w[7:0], "err data");
    rc(A_S1, 8'h27, 8'h04, "late noise kept");
    clr();
    rc(A_S1, 8'h04, 8'h00, "noise clear");
    a = 9'($urandom);
    rxc(a, 1'b0, 1'b0);
    rxc(9'($urandom), 1'b0, 1'b0);
    rc(A_S1, 8'h28, 8'h28, "overrun");
    chk("overrun irq", 1, err_irq_o);
    rc(A_DAT, 8'hff, a[7:0], "kept data");
    wr(A_C3, 8'h00);
    ev(0);
    repeat (3) @(posedge core_clk_i);
    chk("noise masked", 0, err_irq_o);
    wr(A_C3, 8'h04);
    repeat (2) @(posedge core_clk_i);
    chk("noise enabled", 1, err_irq_o);
    clr();
    wr(A_AUX, 8'h03);
    rxc(9'h100 | 9'($urandom), 1'b0, 1'b0);
    clr();
    ev(1);
    rc(A_S2, 8'h02, 8'h02, "break");
    rc(A_S1, 8'h22, 8'h22, "break frame full");
    rc(A_C3, 8'h80, 8'h00, "break ninth");
    @(posedge core_clk_i);
    rxd_i <= 1'b0;
    apb(1'b0, A_DAT, 32'h0);
    ev(1);
    rc(A_S2, 8'h02, 8'h00, "no rearm low");
    @(posedge core_clk_i);
    rxd_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    ev(1);
    rc(A_S2, 8'h02, 8'h02, "rearm");
    clr();
    wr(A_AUX, 8'h00);
    wr(A_AUX, 8'h11);
    ticks(12);
    rc(A_S1, 8'h10, 8'h00, "idle unarmed");
    ev(2);
    rc(A_S2, 8'h01, 8'h01, "active");
    ev(3);
    rc(A_S2, 8'h01, 8'h00, "false start");
    ev(2);
    w = 9'($urandom);
    rxc(w, 1'b0, 1'b0);
    clr();
    @(posedge core_clk_i);
    rxd_i <= 1'b0;
    ticks(2);
    @(posedge core_clk_i);
    rxd_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    ticks(int'(ASFS_IDLE_BITS_8) - 1);
    rc(A_S1, 8'h10, 8'h00, "idle early");
    ticks(1);
    rc(A_S1, 8'h10, 8'h10, "idle");
    chk("idle irq", 1, rx_irq_o);
    rc(A_S2, 8'h01, 8'h00, "idle ends active");
    // Mid-run reset: receive buffer and received ninth bit survive, transmit ninth bit clears
    wr(A_C3, 8'h40);
    rstn_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    rc(A_DAT, 8'hff, w[7:0], "data kept reset");
    rc(A_C3, 8'hc0, {f_ninth(w, 1'b0), 7'h0}, "ninth bits reset");
    report_and_stop();
  end
endmodule
bind asfs_core asfs_core_props props (.*);
`default_nettype wire
